// ==== src/lps_pkg.sv ====
package lps_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int CYC_PER_US = 1000 / CLK_PERIOD_NS;
	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_OCP_EN = 8'h04;
	localparam logic [7:0] REG_OCP_LVL = 8'h08;
	localparam logic [7:0] REG_OCP_DLY = 8'h0C;
	localparam logic [7:0] REG_OV_LVL = 8'h10;
	localparam logic [7:0] REG_OP_LVL = 8'h14;
	localparam logic [7:0] REG_RISE = 8'h18;
	localparam logic [7:0] REG_FALL = 8'h1C;
	localparam logic [7:0] REG_STATUS = 8'h20;
	localparam logic [7:0] REG_PROT_CLR = 8'h24;
	localparam logic [7:0] REG_ERR_POP = 8'h28;
	localparam logic [7:0] REG_ERR_CNT = 8'h2C;
	localparam logic [7:0] REG_ERR_CLR = 8'h30;
	localparam logic [7:0] REG_SAVE = 8'h34;
	localparam logic [7:0] REG_RECALL = 8'h38;
	localparam logic [7:0] REG_EFF_RATE = 8'h3C;
	// ----------------------------------------
	// error queue
	// ----------------------------------------
	localparam int ERR_DEPTH = 20;
	localparam logic [4:0] ERR_FULL = 5'h14;
	localparam logic [8:0] ERR_OVF_MAG = 9'h15E;
	localparam logic [7:0] ERR_OVF_MSG = 8'h01;
	localparam logic [8:0] ERR_CLASS_DIV = 9'h064;
	// ----------------------------------------
	// parameter slots
	// ----------------------------------------
	localparam int SLOTS = 10;
	localparam logic [3:0] SLOT_LAST = 4'h9;
	localparam logic [15:0] RATE_LOW_DIV = 16'h000A;
	typedef enum logic [1:0] {
		RNG_OTHER = 2'b00,
		RNG_CONST_CURRENT_LOW = 2'b01,
		RNG_CONST_CURRENT_HIGH = 2'b10
	} lps_range_t;
	typedef enum logic [2:0] {
		PC_NONE = 3'b000,
		PC_VOLT = 3'b001,
		PC_CURR = 3'b010,
		PC_POWER = 3'b011,
		PC_THERM = 3'b100,
		PC_REV = 3'b101
	} lps_pcode_t;
	typedef struct packed {
		logic inOn;
		lps_range_t range;
		logic ocpEn;
		logic [15:0] ocpLvl;
		logic [15:0] ocpDly;
		logic [15:0] ovLvl;
		logic [15:0] opLvl;
		logic [15:0] rise;
		logic [15:0] fall;
	} lps_params_t;
	localparam lps_params_t PARAM_DEF = '{1'b0, RNG_OTHER, 1'b0, 16'hFFFF, 16'h000A,
		16'hFFFF, 16'hFFFF, 16'h0001, 16'h0001};
	typedef struct packed {
		logic excessVoltageFlag;
		logic excessCurrentFlag;
		logic excessPowerFlag;
		logic thermalTripFlag;
		logic reversedPolarityFlag;
		logic voltageFaultFlag;
		logic protectionSummaryFlag;
	} lps_flags_t;
	typedef struct packed {
		logic [8:0] mag;
		logic [7:0] msg;
	} lps_err_t;
endpackage : lps_pkg

// ==== src/lps_supervisor.sv ====
`timescale 1ns/10ps
module lps_supervisor #(
	parameter logic [15:0] OPP_TIME_US = 16'h0064
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// error reports from command parser
	input wire logic errPush,
	input wire logic [8:0] errCode,
	input wire logic [7:0] errMsg,
	// front-panel keys, one-cycle pulses
	input wire logic keyOnOff,
	input wire logic keyCancelLong,
	input wire logic keyStore,
	input wire logic keyRecall,
	input wire logic [3:0] keySlot,
	// measurements
	input wire logic [15:0] measVolt,
	input wire logic [15:0] measCurr,
	input wire logic [15:0] measPower,
	// fault pins
	input wire logic overTempPin,
	input wire logic reversePin,
	// indicators and control
	output logic inputOn,
	output logic beep,
	output logic cancelLamp,
	output logic faultLamp,
	output lps_pkg::lps_pcode_t protCode,
	output logic latched,
	output lps_pkg::lps_flags_t flags,
	output logic [15:0] riseRateEff,
	output logic [15:0] fallRateEff
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	lps_pkg::lps_params_t p_r;
	lps_pkg::lps_params_t pmem [lps_pkg::SLOTS];
	lps_pkg::lps_err_t emem [lps_pkg::ERR_DEPTH];
	logic [4:0] wp_r, rp_r, cnt_r, cnt_nxt;
	logic ovf_r, boot_r;
	logic [2:0] otSync_r, rvSync_r;
	logic otLvl_r, rvLvl_r;
	logic [6:0] usCnt_r;
	logic usTick_r;
	logic [15:0] ocTimer_r, opTimer_r;
	logic wrEn, clrAct, pop, pushOk, doOvf, errClr;
	logic ovCond, ocCond, opCond, ocTrip, opTrip, tripAny;
	logic doSave, doRecall;
	logic [3:0] slotSel;

	function automatic logic [4:0] incPtr(input logic [4:0] v);
		incPtr = (v == lps_pkg::ERR_FULL - 5'h01) ? 5'h00 : v + 5'h01;
	endfunction : incPtr

	// ----------------------------------------
	// pin synchronisers and microsecond tick
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			otSync_r <= 3'h0;
			rvSync_r <= 3'h0;
			otLvl_r <= 1'b0;
			rvLvl_r <= 1'b0;
		end else begin
			otSync_r <= {otSync_r[1:0], overTempPin};
			rvSync_r <= {rvSync_r[1:0], reversePin};
			// a change counts only once the two later stages agree
			if (otSync_r[1] == otSync_r[2]) otLvl_r <= otSync_r[2];
			if (rvSync_r[1] == rvSync_r[2]) rvLvl_r <= rvSync_r[2];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			usCnt_r <= 7'h00;
			usTick_r <= 1'b0;
		end else begin
			usTick_r <= (usCnt_r == 7'(lps_pkg::CYC_PER_US - 1));
			usCnt_r <= (usCnt_r == 7'(lps_pkg::CYC_PER_US - 1)) ? 7'h00 : usCnt_r + 7'h01;
		end
	end

	// ----------------------------------------
	// command gating
	// ----------------------------------------
	always_comb begin
		wrEn = wr & ~latched;
		clrAct = keyCancelLong | (wr & (addr == lps_pkg::REG_PROT_CLR) & wdata[0]);
		slotSel = keyStore | keyRecall ? keySlot : wdata[3:0];
		doSave = ((wrEn & (addr == lps_pkg::REG_SAVE)) | (keyStore & ~latched))
			& (slotSel <= lps_pkg::SLOT_LAST);
		doRecall = ((wrEn & (addr == lps_pkg::REG_RECALL)) | (keyRecall & ~latched))
			& (slotSel <= lps_pkg::SLOT_LAST);
	end

	// ----------------------------------------
	// fault detection
	// ----------------------------------------
	always_comb begin
		ovCond = measVolt > p_r.ovLvl;
		ocCond = p_r.ocpEn & (measCurr > p_r.ocpLvl);
		opCond = measPower > p_r.opLvl;
		ocTrip = ocCond & (ocTimer_r >= p_r.ocpDly);
		opTrip = opCond & (opTimer_r >= OPP_TIME_US);
		// trips wait one cycle after a clear, so every source is re-evaluated
		tripAny = ~clrAct & (ovCond | ocTrip | opTrip | otLvl_r | rvLvl_r);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ocTimer_r <= 16'h0000;
			opTimer_r <= 16'h0000;
		end else begin
			if (clrAct | ~ocCond | latched)
				ocTimer_r <= 16'h0000;
			else if (usTick_r & ~&ocTimer_r)
				ocTimer_r <= ocTimer_r + 16'h0001;
			if (clrAct | ~opCond | latched)
				opTimer_r <= 16'h0000;
			else if (usTick_r & ~&opTimer_r)
				opTimer_r <= opTimer_r + 16'h0001;
		end
	end

	// ----------------------------------------
	// latched protection
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			latched <= 1'b0;
			beep <= 1'b0;
			cancelLamp <= 1'b0;
			protCode <= lps_pkg::PC_NONE;
			flags <= '0;
		end else begin
			beep <= tripAny & ~latched;
			cancelLamp <= tripAny | ocCond | (latched & ~clrAct);
			if (clrAct) begin
				latched <= 1'b0;
				flags <= '0;
				protCode <= lps_pkg::PC_NONE;
			end else if (tripAny) begin
				latched <= 1'b1;
				if (!latched) begin
					if (ovCond) protCode <= lps_pkg::PC_VOLT;
					else if (ocTrip) protCode <= lps_pkg::PC_CURR;
					else if (opTrip) protCode <= lps_pkg::PC_POWER;
					else if (otLvl_r) protCode <= lps_pkg::PC_THERM;
					else protCode <= lps_pkg::PC_REV;
				end
				if (ovCond) begin
					flags.excessVoltageFlag <= 1'b1;
					flags.voltageFaultFlag <= 1'b1;
				end
				if (ocTrip) begin
					flags.excessCurrentFlag <= 1'b1;
					flags.protectionSummaryFlag <= 1'b1;
				end
				if (opTrip) begin
					flags.excessPowerFlag <= 1'b1;
					flags.protectionSummaryFlag <= 1'b1;
				end
				if (otLvl_r) begin
					flags.thermalTripFlag <= 1'b1;
					flags.protectionSummaryFlag <= 1'b1;
				end
				if (rvLvl_r) begin
					flags.reversedPolarityFlag <= 1'b1;
					flags.voltageFaultFlag <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// live parameters and slots
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			boot_r <= 1'b1;
			p_r <= lps_pkg::PARAM_DEF;
		end else begin
			boot_r <= 1'b0;
			if (boot_r) begin
				p_r <= pmem[0];
			end else if (doRecall) begin
				p_r <= pmem[slotSel];
			end else if (wrEn) begin
				if (addr == lps_pkg::REG_CTRL) begin
					p_r.inOn <= wdata[0];
					p_r.range <= lps_pkg::lps_range_t'(wdata[2:1]);
				end else if (addr == lps_pkg::REG_OCP_EN) p_r.ocpEn <= wdata[0];
				else if (addr == lps_pkg::REG_OCP_LVL) p_r.ocpLvl <= wdata[15:0];
				else if (addr == lps_pkg::REG_OCP_DLY) p_r.ocpDly <= wdata[15:0];
				else if (addr == lps_pkg::REG_OV_LVL) p_r.ovLvl <= wdata[15:0];
				else if (addr == lps_pkg::REG_OP_LVL) p_r.opLvl <= wdata[15:0];
				else if (addr == lps_pkg::REG_RISE) p_r.rise <= wdata[15:0];
				else if (addr == lps_pkg::REG_FALL) p_r.fall <= wdata[15:0];
			end else if (keyOnOff & ~latched) begin
				p_r.inOn <= ~p_r.inOn;
			end
			// a trip drops the input request too, so it stays off after a clear
			if (tripAny) p_r.inOn <= 1'b0;
		end
	end

	// slots reset to defaults, standing in for a blank non-volatile store
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < lps_pkg::SLOTS; i++) pmem[i] <= lps_pkg::PARAM_DEF;
		end else if (doSave) begin
			pmem[slotSel] <= p_r;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			inputOn <= 1'b0;
			riseRateEff <= 16'h0000;
			fallRateEff <= 16'h0000;
		end else begin
			inputOn <= p_r.inOn & ~latched & ~tripAny;
			case (p_r.range)
				lps_pkg::RNG_CONST_CURRENT_HIGH: begin
					riseRateEff <= p_r.rise;
					fallRateEff <= p_r.fall;
				end
				lps_pkg::RNG_CONST_CURRENT_LOW: begin
					riseRateEff <= p_r.rise / lps_pkg::RATE_LOW_DIV;
					fallRateEff <= p_r.fall / lps_pkg::RATE_LOW_DIV;
				end
				default: begin
					riseRateEff <= 16'h0000;
					fallRateEff <= 16'h0000;
				end
			endcase
		end
	end

	// ----------------------------------------
	// error queue
	// ----------------------------------------
	always_comb begin
		errClr = wrEn & (addr == lps_pkg::REG_ERR_CLR);
		pop = rd & (addr == lps_pkg::REG_ERR_POP) & (cnt_r != 5'h00);
		pushOk = errPush & (cnt_r != lps_pkg::ERR_FULL);
		doOvf = errPush & (cnt_r == lps_pkg::ERR_FULL) & ~ovf_r & ~pop;
		if (errClr) cnt_nxt = 5'h00;
		else cnt_nxt = cnt_r + {4'h0, pushOk} - {4'h0, pop};
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wp_r <= 5'h00;
			rp_r <= 5'h00;
			cnt_r <= 5'h00;
			ovf_r <= 1'b0;
			faultLamp <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			faultLamp <= cnt_nxt != 5'h00;
			if (errClr) begin
				wp_r <= 5'h00;
				rp_r <= 5'h00;
				ovf_r <= 1'b0;
			end else begin
				if (pop) begin
					rp_r <= incPtr(rp_r);
					ovf_r <= 1'b0;
				end
				if (pushOk) wp_r <= incPtr(wp_r);
				if (doOvf) ovf_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!errClr && pushOk) emem[wp_r] <= '{errCode, errMsg};
		else if (!errClr && doOvf)
			emem[wp_r == 5'h00 ? lps_pkg::ERR_FULL - 5'h01 : wp_r - 5'h01]
				<= '{lps_pkg::ERR_OVF_MAG, lps_pkg::ERR_OVF_MSG};
	end

	// ----------------------------------------
	// register read
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= 32'h0000_0000;
		end else begin
			rdata <= 32'h0000_0000;
			if (!rd) rdata <= 32'h0000_0000;
			else if (addr == lps_pkg::REG_CTRL) rdata <= {29'h0, p_r.range, p_r.inOn};
			else if (addr == lps_pkg::REG_OCP_EN) rdata <= {31'h0, p_r.ocpEn};
			else if (addr == lps_pkg::REG_OCP_LVL) rdata <= {16'h0, p_r.ocpLvl};
			else if (addr == lps_pkg::REG_OCP_DLY) rdata <= {16'h0, p_r.ocpDly};
			else if (addr == lps_pkg::REG_OV_LVL) rdata <= {16'h0, p_r.ovLvl};
			else if (addr == lps_pkg::REG_OP_LVL) rdata <= {16'h0, p_r.opLvl};
			else if (addr == lps_pkg::REG_RISE) rdata <= {16'h0, p_r.rise};
			else if (addr == lps_pkg::REG_FALL) rdata <= {16'h0, p_r.fall};
			else if (addr == lps_pkg::REG_STATUS)
				rdata <= {19'h0, protCode, ocCond, latched, 1'b0, flags};
			else if (addr == lps_pkg::REG_ERR_CNT) rdata <= {26'h0, ovf_r, cnt_r};
			else if (addr == lps_pkg::REG_EFF_RATE) rdata <= {fallRateEff, riseRateEff};
			else if (addr == lps_pkg::REG_ERR_POP && cnt_r != 5'h00)
				// class is the hundreds digit; code goes out as a negative number
				rdata <= {5'h0, 3'(emem[rp_r].mag / lps_pkg::ERR_CLASS_DIV),
					emem[rp_r].msg, 16'(-{7'h0, emem[rp_r].mag})};
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_tripOff;
		@(posedge clk) disable iff (rst) tripAny |=> !inputOn && latched && flags != '0;
	endproperty
	a_tripOff: assert property (p_tripOff) else $error("trip did not latch off");
	property p_latchHold;
		@(posedge clk) disable iff (rst) latched && !clrAct |=> latched && !inputOn;
	endproperty
	a_latchHold: assert property (p_latchHold) else $error("latch left unasked");
	property p_clrDrop;
		@(posedge clk) disable iff (rst) latched && clrAct |=> !latched && flags == '0;
	endproperty
	a_clrDrop: assert property (p_clrDrop) else $error("clear not honoured");
	property p_reTrip;
		@(posedge clk) disable iff (rst) clrAct ##1 (ovCond && !clrAct) |=> latched;
	endproperty
	a_reTrip: assert property (p_reTrip) else $error("persisting fault not relatched");
	property p_ovFlags;
		@(posedge clk) disable iff (rst) ovCond && !clrAct
			|=> flags.excessVoltageFlag && flags.voltageFaultFlag;
	endproperty
	a_ovFlags: assert property (p_ovFlags) else $error("voltage flags missing");
	property p_ocWait;
		@(posedge clk) disable iff (rst) ocCond && !ocTrip |=> cancelLamp;
	endproperty
	a_ocWait: assert property (p_ocWait) else $error("cancel lamp off in delay");
	property p_ocFlags;
		@(posedge clk) disable iff (rst) ocTrip && !clrAct
			|=> flags.excessCurrentFlag && flags.protectionSummaryFlag;
	endproperty
	a_ocFlags: assert property (p_ocFlags) else $error("current flags missing");
	property p_fault;
		@(posedge clk) disable iff (rst) pushOk && !errClr |=> faultLamp && cnt_r != 5'h00;
	endproperty
	a_fault: assert property (p_fault) else $error("fault lamp not lit");
	property p_ovf;
		@(posedge clk) disable iff (rst) doOvf && !errClr
			|=> ovf_r && cnt_r == lps_pkg::ERR_FULL;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow not handled");
	property p_pop;
		@(posedge clk) disable iff (rst) pop && !errPush && !errClr
			|=> cnt_r == $past(cnt_r) - 5'h01;
	endproperty
	a_pop: assert property (p_pop) else $error("read did not remove entry");
	c_trip: cover property (@(posedge clk) disable iff (rst) tripAny ##1 clrAct ##1 !latched);
	c_ovf: cover property (@(posedge clk) disable iff (rst) doOvf);
	c_ocRestart: cover property (@(posedge clk) disable iff (rst) ocCond && clrAct && !latched);
endmodule : lps_supervisor

// ==== tb/lps_host_model.sv ====
`timescale 1ns/10ps
module lps_host_model (
	// clock
	input wire logic clk,
	// error reports
	output logic errPush,
	output logic [8:0] errCode,
	output logic [7:0] errMsg,
	// keys
	output logic keyOnOff,
	output logic keyCancelLong,
	output logic keyStore,
	output logic keyRecall,
	output logic [3:0] keySlot
);
	initial begin
		errPush = 1'b0;
		errCode = 9'h000;
		errMsg = 8'h00;
		keyOnOff = 1'b0;
		keyCancelLong = 1'b0;
		keyStore = 1'b0;
		keyRecall = 1'b0;
		keySlot = 4'h0;
	end
	// ----------------------------------------
	// parser error reports, one per cycle with no gap
	// ----------------------------------------
	task automatic push_burst(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			errPush <= 1'b1;
			errCode <= 9'(100 + 17 * i);
			errMsg <= 8'(i);
		end
		@(posedge clk);
		errPush <= 1'b0;
		errCode <= ~errCode;
	endtask : push_burst
	// ----------------------------------------
	// key pulses, one cycle each
	// ----------------------------------------
	task automatic cancel_long();
		@(posedge clk);
		keyCancelLong <= 1'b1;
		@(posedge clk);
		keyCancelLong <= 1'b0;
	endtask : cancel_long
	task automatic on_off();
		@(posedge clk);
		keyOnOff <= 1'b1;
		@(posedge clk);
		keyOnOff <= 1'b0;
	endtask : on_off
	task automatic slot_key(input logic store, input logic [3:0] slot);
		@(posedge clk);
		keyStore <= store;
		keyRecall <= !store;
		keySlot <= slot;
		@(posedge clk);
		keyStore <= 1'b0;
		keyRecall <= 1'b0;
		keySlot <= ~slot;
	endtask : slot_key
endmodule : lps_host_model

// ==== tb/lps_supervisor_tb.sv ====
`timescale 1ns/10ps
module lps_supervisor_tb;
	logic clk, rst, wr, rd, overTempPin, reversePin;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, d;
	logic [15:0] measVolt, measCurr, measPower, riseRateEff, fallRateEff;
	logic errPush, keyOnOff, keyCancelLong, keyStore, keyRecall;
	logic [8:0] errCode;
	logic [7:0] errMsg;
	logic [3:0] keySlot;
	logic inputOn, beep, cancelLamp, faultLamp, latched;
	lps_pkg::lps_pcode_t protCode;
	lps_pkg::lps_flags_t flags;
	int n_errors = 0;
	int compares = 0;

	lps_supervisor #(.OPP_TIME_US(16'h0002)) u_lps_supervisor (.clk(clk), .rst(rst),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .errPush(errPush),
		.errCode(errCode), .errMsg(errMsg), .keyOnOff(keyOnOff), .keyCancelLong(keyCancelLong),
		.keyStore(keyStore), .keyRecall(keyRecall), .keySlot(keySlot), .measVolt(measVolt),
		.measCurr(measCurr), .measPower(measPower), .overTempPin(overTempPin),
		.reversePin(reversePin), .inputOn(inputOn), .beep(beep), .cancelLamp(cancelLamp),
		.faultLamp(faultLamp), .protCode(protCode), .latched(latched), .flags(flags),
		.riseRateEff(riseRateEff), .fallRateEff(fallRateEff));
	lps_host_model u_lps_host_model (.clk(clk), .errPush(errPush), .errCode(errCode),
		.errMsg(errMsg), .keyOnOff(keyOnOff), .keyCancelLong(keyCancelLong),
		.keyStore(keyStore), .keyRecall(keyRecall), .keySlot(keySlot));

	always #5 clk = ~clk;
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic end_of_test();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", name, e, g);
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask : rd_reg
	task automatic step();
		@(posedge clk);
		#1;
	endtask : step
	// waits bounded for the latch, then checks every trip output
	task automatic wait_trip(input logic [2:0] code, input logic [6:0] f, input int maxCyc);
		int n = 0;
		while (latched !== 1'b1 && n < maxCyc) begin
			step();
			n++;
		end
		chk("latched", 1, {31'h0, latched});
		chk("beep", 1, {31'h0, beep});
		chk("inputOn", 0, {31'h0, inputOn});
		chk("cancelLamp", 1, {31'h0, cancelLamp});
		chk("protCode", {29'h0, code}, {29'h0, protCode});
		chk("flags", {25'h0, f}, {25'h0, flags});
		step();
		chk("beepEnd", 0, {31'h0, beep});
	endtask : wait_trip
	// condition already removed; pins need a few cycles to pass the synchroniser
	task automatic release_check(input logic useKey);
		repeat (6) step();
		if (useKey) u_lps_host_model.cancel_long();
		else wr_reg(lps_pkg::REG_PROT_CLR, 32'h1);
		#1 chk("flagsClr", 0, {25'h0, flags});
		step();
		chk("latchedClr", 0, {31'h0, latched});
	endtask : release_check
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_err();
		rd_reg(lps_pkg::REG_ERR_POP, d);
		chk("popEmpty", 0, d);
		// the 22nd report must be dropped once the queue has overflowed
		u_lps_host_model.push_burst(22);
		step();
		chk("faultLamp", 1, {31'h0, faultLamp});
		rd_reg(lps_pkg::REG_ERR_CNT, d);
		chk("errCntFull", 32'h34, d);
		for (int i = 0; i < 20; i++) begin
			automatic int mag = (i < 19) ? 100 + 17 * i : 350;
			automatic int msg = (i < 19) ? i : 1;
			rd_reg(lps_pkg::REG_ERR_POP, d);
			chk("pop", {5'h0, 3'(mag / 100), 8'(msg), 16'(-mag)}, d);
		end
		rd_reg(lps_pkg::REG_ERR_CNT, d);
		chk("errCntEmpty", 0, d);
		step();
		chk("faultLampOff", 0, {31'h0, faultLamp});
		u_lps_host_model.push_burst(2);
		wr_reg(lps_pkg::REG_ERR_CLR, 32'h1);
		rd_reg(lps_pkg::REG_ERR_CNT, d);
		chk("errCntClr", 0, d);
	endtask : t_err
	task automatic t_slots();
		wr_reg(lps_pkg::REG_RISE, 32'h0000_0032);
		wr_reg(lps_pkg::REG_FALL, 32'h0000_001E);
		wr_reg(lps_pkg::REG_CTRL, 32'h2);
		u_lps_host_model.slot_key(1'b1, 4'h3);
		step();
		chk("riseLow", 16'h0005, {16'h0, riseRateEff});
		chk("fallLow", 16'h0003, {16'h0, fallRateEff});
		wr_reg(lps_pkg::REG_RISE, 32'h0000_0064);
		wr_reg(lps_pkg::REG_CTRL, 32'h4);
		wr_reg(lps_pkg::REG_SAVE, 32'hA);
		wr_reg(lps_pkg::REG_RECALL, 32'hA);
		repeat (2) step();
		chk("riseHigh", 16'h0064, {16'h0, riseRateEff});
		wr_reg(lps_pkg::REG_CTRL, 32'h0);
		repeat (2) step();
		chk("riseOther", 0, {16'h0, riseRateEff});
		u_lps_host_model.slot_key(1'b0, 4'h3);
		repeat (2) step();
		rd_reg(lps_pkg::REG_EFF_RATE, d);
		chk("effRecall", 32'h00030005, d);
	endtask : t_slots
	task automatic t_ov();
		wr_reg(lps_pkg::REG_OV_LVL, 32'h0000_0064);
		wr_reg(lps_pkg::REG_CTRL, 32'h1);
		step();
		chk("inputOn", 1, {31'h0, inputOn});
		@(posedge clk) measVolt <= 16'h00C8;
		wait_trip(3'h1, 7'b1000010, 4);
		rd_reg(lps_pkg::REG_STATUS, d);
		chk("status", 32'h542, d);
		wr_reg(lps_pkg::REG_CTRL, 32'h1);
		// a write while latched must not move the trip level
		wr_reg(lps_pkg::REG_OV_LVL, 32'h0000_012C);
		u_lps_host_model.on_off();
		repeat (2) step();
		chk("inputHeld", 0, {31'h0, inputOn});
		rd_reg(lps_pkg::REG_OV_LVL, d);
		chk("ovLvlHeld", 32'h0000_0064, d);
		wr_reg(lps_pkg::REG_PROT_CLR, 32'h1);
		#1 chk("latchedGone", 0, {31'h0, latched});
		step();
		chk("relatch", 1, {31'h0, latched});
		@(posedge clk) measVolt <= 16'h0000;
		release_check(1'b0);
		u_lps_host_model.on_off();
		step();
		chk("inputBack", 1, {31'h0, inputOn});
	endtask : t_ov
	task automatic t_oc();
		wr_reg(lps_pkg::REG_OCP_LVL, 32'h0000_0064);
		wr_reg(lps_pkg::REG_OCP_DLY, 32'h0000_0003);
		wr_reg(lps_pkg::REG_OCP_EN, 32'h1);
		@(posedge clk) measCurr <= 16'h00C8;
		// a 3 us delay trips 201 to 300 cycles after a restart, whatever the tick phase;
		// without the restart the second pass would already have tripped
		for (int k = 0; k < 2; k++) begin
			repeat (180) step();
			chk("ocNoTrip", 0, {31'h0, latched});
			chk("ocInputOn", 1, {31'h0, inputOn});
			chk("ocLamp", 1, {31'h0, cancelLamp});
			rd_reg(lps_pkg::REG_STATUS, d);
			chk("ocStatus", 32'h0000_0200, d);
			if (k == 0) u_lps_host_model.cancel_long();
		end
		wait_trip(3'h2, 7'b0100001, 300);
		@(posedge clk) measCurr <= 16'h0000;
		release_check(1'b1);
		wr_reg(lps_pkg::REG_OCP_EN, 32'h0);
	endtask : t_oc
	task automatic t_op();
		wr_reg(lps_pkg::REG_OP_LVL, 32'h0000_000A);
		@(posedge clk) measPower <= 16'h0014;
		repeat (100) step();
		chk("opNoTrip", 0, {31'h0, latched});
		wait_trip(3'h3, 7'b0010001, 300);
		@(posedge clk) measPower <= 16'h0000;
		release_check(1'b0);
	endtask : t_op
	task automatic t_pin(input logic isRev);
		@(posedge clk);
		overTempPin <= !isRev;
		reversePin <= isRev;
		if (isRev) wait_trip(3'h5, 7'b0000110, 10);
		else wait_trip(3'h4, 7'b0001001, 10);
		@(posedge clk);
		overTempPin <= 1'b0;
		reversePin <= 1'b0;
		release_check(1'b1);
	endtask : t_pin
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		{wr, rd, overTempPin, reversePin} = 4'h0;
		addr = 8'h00;
		wdata = 32'h0;
		{measVolt, measCurr, measPower} = 48'h0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (2) step();
		chk("bootRate", 0, {16'h0, riseRateEff});
		chk("bootFlags", 0, {25'h0, flags});
		t_err();
		t_slots();
		t_ov();
		t_oc();
		t_op();
		t_pin(1'b0);
		t_pin(1'b1);
		end_of_test();
	end
	initial begin
		#100000;
		n_errors++;
		end_of_test();
	end
endmodule : lps_supervisor_tb
